// [hdl/hbc_pkg.sv]
// Package for the half-bridge controller: pin bundles, modes and timing constants
package hbc_pkg;

	localparam int MCLK_HZ         = 40000000;
	localparam int MCLK_PERIOD_NS  = 25;
	// Least hold of the fault latch clear pulse, ns
	localparam int CLEAR_PULSE_NS  = 200;
	localparam int CLEAR_PULSE_CYC = (CLEAR_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int SYNC_STAGES     = 2;
	localparam logic [1:0] PHASE_A = 2'h0;
	localparam logic [1:0] PHASE_B = 2'h1;

	// Commands towards the bridge, one set per phase
	typedef struct packed {
		logic high_cmd;
		logic low_cmd;
	} hbc_phase_cmd_t;

	// Fault pins coming back from the bridge
	typedef struct packed {
		logic short_fault;
		logic temp_fault;
		logic limit_flag;
	} hbc_fault_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_RUN   = 4'h2,
		ST_FAULT = 4'h4,
		ST_CLEAR = 4'h8
	} hbc_state_t;

endpackage

// [hdl/hbc_ctrl.sv]
// Controller driving a dual half-bridge: PWM commands, fault latch and disables
`timescale 1ns/1ps
module hbc_ctrl
	import hbc_pkg::*;
#(
	parameter int PWM_PERIOD = 400,
	parameter int CLEAR_CYC  = CLEAR_PULSE_CYC
) (
	input  wire logic                       mclk_i,
	input  wire logic                       srst_i,
	input  wire logic                       enable_i,
	input  wire logic                       dir_i,
	input  wire logic [15:0]                duty_i,
	input  wire logic                       fault_ack_i,
	input  wire logic                       limit_off_i,
	input  wire logic                       short_fault_out_i,
	input  wire logic                       temp_fault_i,
	input  wire logic                       limit_flag_disable_a_i,
	output logic                            phase_a_high_cmd_o,
	output logic                            phase_a_low_cmd_o,
	output logic                            phase_b_high_cmd_o,
	output logic                            phase_b_low_cmd_o,
	output logic                            disable_b_in_o,
	output logic                            limit_flag_disable_a_o,
	output logic                            limit_flag_disable_a_oe_o,
	output logic                            fault_latched_o,
	output logic                            short_seen_o,
	output logic                            temp_seen_o,
	output logic                            limit_active_o
);

	hbc_fault_t sync1;
	hbc_fault_t sync2;
	hbc_state_t state;
	hbc_state_t next_state;
	logic [15:0] pwm_cnt;
	logic [15:0] clr_cnt;
	logic [15:0] duty_eff;
	logic        short_s;
	logic        temp_s;
	logic        flag_s;
	logic        fault_hit;
	logic        pwm_on;
	logic        drive_ok;
	logic        next_a_high;
	logic        next_a_low;
	logic        next_b_high;
	logic        next_b_low;

	// Fault pins cross into our clock domain through two flops
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= '{short_fault_out_i, temp_fault_i, limit_flag_disable_a_i};
			sync2 <= sync1;
		end
	end

	assign short_s   = sync2.short_fault;
	assign temp_s    = sync2.temp_fault;
	assign flag_s    = sync2.limit_flag;
	assign fault_hit = short_s | temp_s;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:  if (fault_hit) next_state = ST_FAULT; else if (enable_i) next_state = ST_RUN;
			ST_RUN:   if (fault_hit) next_state = ST_FAULT; else if (!enable_i) next_state = ST_IDLE;
			ST_FAULT: if (fault_ack_i && !fault_hit) next_state = ST_CLEAR;
			ST_CLEAR: if (clr_cnt == 16'h0000) next_state = ST_IDLE;
			default:  next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			clr_cnt <= 16'h0000;
		end else if (state == ST_FAULT) begin
			clr_cnt <= 16'(CLEAR_CYC - 1);
		end else if (clr_cnt != 16'h0000) begin
			clr_cnt <= clr_cnt - 16'h0001;
		end
	end

	// Free-running PWM period; the rising top edge each period re-arms the limit
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			pwm_cnt <= 16'h0000;
		end else if (pwm_cnt == 16'(PWM_PERIOD - 1)) begin
			pwm_cnt <= 16'h0000;
		end else begin
			pwm_cnt <= pwm_cnt + 16'h0001;
		end
	end

	// Duty clamped to 1..PWM_PERIOD-1 so every period has a top edge; slot 0 stays off
	assign duty_eff = (duty_i == 16'h0000) ? 16'h0001 :
			  ((duty_i >= 16'(PWM_PERIOD)) ? 16'(PWM_PERIOD - 1) : duty_i);
	assign pwm_on   = (pwm_cnt != 16'h0000) && (pwm_cnt <= duty_eff);
	assign drive_ok = (state == ST_RUN) && !fault_hit;
	// With dir_i low phase A drives high side and phase B low side, swapped with dir_i high; off is both low
	assign next_a_high = drive_ok && pwm_on && !dir_i;
	assign next_a_low  = drive_ok && (dir_i ? pwm_on : 1'b0);
	assign next_b_high = drive_ok && pwm_on && dir_i;
	assign next_b_low  = drive_ok && (dir_i ? 1'b0 : pwm_on);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			phase_a_high_cmd_o        <= 1'b0;
			phase_a_low_cmd_o         <= 1'b0;
			phase_b_high_cmd_o        <= 1'b0;
			phase_b_low_cmd_o         <= 1'b0;
			disable_b_in_o            <= 1'b1;
			limit_flag_disable_a_o    <= 1'b0;
			limit_flag_disable_a_oe_o <= 1'b0;
			fault_latched_o           <= 1'b0;
			short_seen_o              <= 1'b0;
			temp_seen_o               <= 1'b0;
			limit_active_o            <= 1'b0;
		end else begin
			phase_a_high_cmd_o        <= next_a_high;
			phase_a_low_cmd_o         <= next_a_low;
			phase_b_high_cmd_o        <= next_b_high;
			phase_b_low_cmd_o         <= next_b_low;
			disable_b_in_o            <= (next_state != ST_RUN);
			limit_flag_disable_a_o    <= 1'b0;
			limit_flag_disable_a_oe_o <= limit_off_i;
			fault_latched_o           <= (next_state == ST_FAULT);
			short_seen_o              <= short_s;
			temp_seen_o               <= temp_s;
			limit_active_o            <= flag_s && !limit_off_i;
		end
	end

	AST_FAULT_DISABLES: assert property (@(posedge mclk_i) disable iff (srst_i)
		fault_hit |=> disable_b_in_o && !phase_a_high_cmd_o && !phase_b_high_cmd_o)
		else $error("fault did not disable bridge");
	AST_SHORT_STOPS: assert property (@(posedge mclk_i) disable iff (srst_i)
		$rose(short_s) |=> !phase_a_high_cmd_o && !phase_a_low_cmd_o && !phase_b_high_cmd_o && !phase_b_low_cmd_o)
		else $error("commands not stopped on short fault");
	AST_LATCH_HOLDS: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state == ST_FAULT && !fault_ack_i) |=> state == ST_FAULT)
		else $error("fault latch cleared without acknowledge");
	AST_NO_SHOOT: assert property (@(posedge mclk_i) disable iff (srst_i)
		!(phase_a_high_cmd_o && phase_a_low_cmd_o) && !(phase_b_high_cmd_o && phase_b_low_cmd_o))
		else $error("phase commanded with both sides high");
	AST_CLEAR_LEN: assert property (@(posedge mclk_i) disable iff (srst_i)
		$rose(state == ST_CLEAR) |-> (state == ST_CLEAR)[*2])
		else $error("clear pulse too short");
	AST_EDGE_EACH: assert property (@(posedge mclk_i) disable iff (srst_i)
		pwm_cnt == 16'h0000 |=> !phase_a_high_cmd_o && !phase_b_high_cmd_o)
		else $error("no low slot for top edge");
	AST_LIMIT_PIN: assert property (@(posedge mclk_i) disable iff (srst_i)
		limit_off_i |=> limit_flag_disable_a_oe_o && !limit_flag_disable_a_o)
		else $error("limit disable pin not held low");
	AST_LIMIT_SEEN: assert property (@(posedge mclk_i) disable iff (srst_i)
		(flag_s && !limit_off_i) |=> limit_active_o)
		else $error("limit flag not reported");

	// Duty floor: a running bridge sees a top pulse every period
	AST_DUTY_FLOOR: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state == ST_RUN && !fault_hit && pwm_cnt == 16'h0001) |=> phase_a_high_cmd_o || phase_b_high_cmd_o)
		else $error("top command missing in period");

	// Latch set dominates; a fault arriving during clear is caught once back in idle
	AST_FAULT_LATCHES: assert property (@(posedge mclk_i) disable iff (srst_i)
		(fault_hit && state != ST_CLEAR) |=> fault_latched_o)
		else $error("fault did not set latch");
	AST_LATCHED_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
		fault_latched_o |-> disable_b_in_o && !phase_a_high_cmd_o && !phase_a_low_cmd_o &&
			!phase_b_high_cmd_o && !phase_b_low_cmd_o)
		else $error("bridge driven while latch set");
	AST_ACK_CLEARS: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state == ST_FAULT && fault_ack_i && !fault_hit) |=> !fault_latched_o && state == ST_CLEAR)
		else $error("acknowledge did not clear latch");
	AST_NO_DRIVE_CLEAR: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state == ST_FAULT || state == ST_CLEAR) |=> !phase_a_high_cmd_o && !phase_a_low_cmd_o &&
			!phase_b_high_cmd_o && !phase_b_low_cmd_o)
		else $error("commands driven before latch cleared");

	// Run request handling towards the second disable
	AST_RUN_DRIVES: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state == ST_RUN && enable_i && !fault_hit) |=> !disable_b_in_o)
		else $error("disable held while running");
	AST_IDLE_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state == ST_RUN && !enable_i && !fault_hit) |=> disable_b_in_o ##1
			(!phase_a_high_cmd_o && !phase_a_low_cmd_o && !phase_b_high_cmd_o && !phase_b_low_cmd_o))
		else $error("bridge not parked on stop");

	// Status copies seen by software
	AST_SHORT_SEEN: assert property (@(posedge mclk_i) disable iff (srst_i)
		$rose(short_s) |=> short_seen_o)
		else $error("short fault not reported");
	AST_LIMIT_MASK: assert property (@(posedge mclk_i) disable iff (srst_i)
		limit_off_i |=> !limit_active_o)
		else $error("limit reported while disabled");

endmodule

// [verification/hbc_bridge_model.sv]
// Behavioural dual half-bridge seen by the controller
`timescale 1ns/1ps
module hbc_bridge_model (
	input  wire logic       a_hi_i,
	input  wire logic       a_lo_i,
	input  wire logic       b_hi_i,
	input  wire logic       b_lo_i,
	input  wire logic       dis_b_i,
	input  wire logic       pin_low_i,
	input  wire logic       over_i,
	input  wire logic       short_i,
	input  wire logic       hot_i,
	input  wire logic       supply_low_i,
	output logic            short_o,
	output logic            hot_o,
	output logic            lim_o,
	output logic [1:0]      fet_a_o,
	output logic [1:0]      fet_b_o,
	output logic            sense_a_o
);
	logic lim = 1'b0;
	logic off;
	// Set-dominant; re-arm only on a top command rise
	always @(posedge over_i or posedge a_hi_i or posedge b_hi_i) begin
		lim <= over_i;
	end
	assign lim_o     = lim & ~pin_low_i;
	assign off       = dis_b_i | lim_o | supply_low_i;
	assign fet_a_o   = off ? 2'h0 : {a_hi_i & ~a_lo_i, a_lo_i & ~a_hi_i};
	assign fet_b_o   = off ? 2'h0 : {b_hi_i & ~b_lo_i, b_lo_i & ~b_hi_i};
	assign sense_a_o = fet_a_o[1];
	assign short_o   = short_i;
	assign hot_o     = hot_i;
endmodule

// [verification/tb_half_bridge_fault_current_limit.sv]
// Bench: controller against the bridge model
`timescale 1ns/1ps
module tb_half_bridge_fault_current_limit;
	import hbc_pkg::*;
	localparam int TB_PERIOD = 8;
	logic mclk_i = 0, srst_i = 1, en = 0, dir = 0, ack = 0, loff = 0, uv = 0;
	logic [15:0] duty = 16'h0003;
	logic over = 0, sh = 0, hot = 0, prev;
	logic a_hi, a_lo, b_hi, b_lo, dis_b, lo, oe, lat, s_seen, t_seen, l_act, sh_p, hot_p, lim;
	logic [1:0] fa, fb;
	int err_total = 0, num_checks = 0, cyc = 0, n, hi, bad;
	always #12.5 mclk_i = ~mclk_i;
	hbc_ctrl #(.PWM_PERIOD(TB_PERIOD), .CLEAR_CYC(2)) DUT (.mclk_i(mclk_i), .srst_i(srst_i), .enable_i(en), .dir_i(dir),
		.duty_i(duty), .fault_ack_i(ack), .limit_off_i(loff), .short_fault_out_i(sh_p), .temp_fault_i(hot_p),
		.limit_flag_disable_a_i(oe ? lo : lim), .phase_a_high_cmd_o(a_hi), .phase_a_low_cmd_o(a_lo),
		.phase_b_high_cmd_o(b_hi), .phase_b_low_cmd_o(b_lo), .disable_b_in_o(dis_b), .limit_flag_disable_a_o(lo),
		.limit_flag_disable_a_oe_o(oe), .fault_latched_o(lat), .short_seen_o(s_seen), .temp_seen_o(t_seen),
		.limit_active_o(l_act));
	hbc_bridge_model BRG (.a_hi_i(a_hi), .a_lo_i(a_lo), .b_hi_i(b_hi), .b_lo_i(b_lo), .dis_b_i(dis_b),
		.pin_low_i(oe & ~lo), .over_i(over), .short_i(sh), .hot_i(hot), .supply_low_i(uv), .short_o(sh_p),
		.hot_o(hot_p), .lim_o(lim), .fet_a_o(fa), .fet_b_o(fb), .sense_a_o());
	task automatic step(input int k);
		repeat (k) @(posedge mclk_i);
		#2;
	endtask
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic complete_run;
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Top commands must rise once each period, high for the clamped duty
	task automatic t_run(input logic d, input logic [15:0] du);
		int want;
		want = (du == 16'h0000) ? 1 : ((du >= 16'(TB_PERIOD)) ? TB_PERIOD - 1 : int'(du));
		dir = d;
		duty = du;
		step(2 * TB_PERIOD);
		n = 0;
		hi = 0;
		bad = 0;
		repeat (2 * TB_PERIOD) begin
			prev = d ? b_hi : a_hi;
			step(1);
			if (!prev && (d ? b_hi : a_hi)) n++;
			if (d ? b_hi : a_hi) hi++;
			if ((d ? a_lo : b_lo) !== (d ? b_hi : a_hi) || (d ? a_hi : b_hi) || (d ? b_lo : a_lo)) bad++;
		end
		chk(n == 2 && hi == 2 * want && dis_b === 1'b0, "top edges missing");
		chk(bad == 0, "wrong phase pattern");
	endtask
	// Dropping the run request parks the bridge
	task automatic t_stop;
		en = 0;
		step(3);
		chk({a_hi, a_lo, b_hi, b_lo} === 4'h0 && dis_b === 1'b1, "stop not honoured");
		en = 1;
		step(3);
		chk(dis_b === 1'b0, "run not resumed");
	endtask
	// Lockout keeps the FETs off and raises no fault pin
	task automatic t_lockout;
		uv = 1;
		step(4);
		chk(fa === 2'h0 && fb === 2'h0 && {s_seen, t_seen, l_act, lat} === 4'h0, "lockout not silent");
		uv = 0;
		step(2);
	endtask
	// Fault shuts the bridge, ack refused while fault stands
	task automatic t_fault(input logic is_short);
		sh = is_short;
		hot = !is_short;
		step(3);
		chk({a_hi, a_lo, b_hi, b_lo} === 4'h0 && fa === 2'h0 && fb === 2'h0, "commands not off");
		chk(dis_b === 1'b1 && lat === 1'b1 && s_seen === is_short && t_seen === !is_short, "latch not set");
		ack = 1;
		step(5);
		chk(lat === 1'b1, "ack cleared live fault");
		sh = 0;
		hot = 0;
		step(8);
		ack = 0;
		chk(lat === 1'b0, "latch not cleared");
		t_run(is_short, 16'h0002);
	endtask
	// Limit trip held over a top edge, pin grounded to disable it, then re-armed
	task automatic t_limit;
		over = 1;
		step(3 + TB_PERIOD);
		chk(l_act === 1'b1 && fa === 2'h0 && fb === 2'h0, "limit not held");
		loff = 1;
		step(2);
		chk(oe === 1'b1 && lo === 1'b0 && l_act === 1'b0 && fa === {a_hi & ~a_lo, a_lo & ~a_hi},
			"limit pin not grounded");
		over = 0;
		loff = 0;
		step(2 * TB_PERIOD);
		chk(l_act === 1'b0, "limit not re-armed");
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			err_total++;
			$display("MISMATCH %0t timeout", $time);
			complete_run();
		end
	end
	initial begin
		step(20);
		chk({a_hi, a_lo, b_hi, b_lo, dis_b} === 5'h01, "reset outputs");
		srst_i = 0;
		en = 1;
		step(2);
		t_run(0, 16'h0003);
		t_run(1, 16'h0000);
		t_run(0, 16'hFFFF);
		t_fault(1);
		t_fault(0);
		t_stop();
		t_lockout();
		t_limit();
		complete_run();
	end
endmodule
